// file: ssp_top.sv
// Purpose: serial port control register B, flags and interrupt requests
// Assumes: AHB-Lite slave, zero wait states; link pins sampled by clk
// Notes: link bit clock must be slower than clk / 4
//
// What this block does
// - Receive exception request when enabled and full plus overrun both set.
// - Status read then receive data read clears overrun and its request.
// - Transmit exception request when enabled and empty plus underrun set.
// - Underrun clears after status read then writes to all enabled transmitters.
// - Network mode: transmit last-slot interrupt when final slot begins.
// - Divider field zero blocks both last-slot interrupts.
// - Receive data request while enable and full flag both set.
// - Reading receive data clears full flag and its request.
// - Overrun with exception enable requests exception vector, above normal receive.
// - Transmit request while enable and empty flag both set.
// - Writing all enabled transmit data or slot register clears empty flag.
// - Underrun with exception enable requests exception vector, above normal transmit.
// - Hardware or software reset clears the whole control register.
// - Network mode: cleared transmitter stops after word, pin floats till frame.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ssp_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sclk_pin,
    input wire logic fs_pin,
    input wire logic rxd_pin,
    output logic [2:0] tx_data_out,
    output logic [2:0] tx_oe_n,
    output logic req_rx,
    output logic req_rx_exc,
    output logic req_tx,
    output logic req_tx_exc,
    output logic irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] ctrl;
        logic [4:0] dc;
        logic rx_full_flag;
        logic rx_overrun_flag;
        logic tx_empty_flag;
        logic tx_underrun_flag;
        logic [7:0] rx_data;
        logic [2:0][7:0] tx_buf;
        logic [7:0] rx_sh;
        logic [2:0][7:0] tx_sh;
        logic [3:0] bit_cnt;
        logic [4:0] slot;
        ssp_pkg::ssp_link_t link;
        logic [2:0] tx_act;
        logic [2:0] tx_hold;
        logic [2:0] tx_out;
        logic [2:0] tx_oe_n;
        logic [2:0] tx_wr;
        logic rx_arm;
        logic tx_arm;
        logic sclk_d;
        logic ap_valid;
        logic ap_wr;
        logic [5:0] ap_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic [5:0] irq_mask;
        logic req_rx;
        logic req_rx_exc;
        logic req_tx;
        logic req_tx_exc;
        logic ev_rx_last;
        logic ev_tx_last;
    } ssp_state_t;

    ssp_state_t s;
    ssp_state_t n;
    logic [2:0] pins_s;
    logic sclk_s;
    logic fs_s;
    logic rxd_s;
    logic [5:0] irq_stat;
    logic [5:0] irq_set;
    logic [5:0] irq_clr;
    logic [2:0] te;
    logic [2:0] te_new;
    logic [2:0] tx_en;
    logic net;
    logic last_ok;
    logic take;
    logic wr_dp;
    logic sclk_rise;
    logic new_word;
    logic word_end;

    // ------------------------------------------------------------
    // Pin synchronisers and interrupt status
    // ------------------------------------------------------------
    ssp_sync #(.W(3)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({rxd_pin, fs_pin, sclk_pin}),
        .q(pins_s)
    );
    assign sclk_s = pins_s[0];
    assign fs_s = pins_s[1];
    assign rxd_s = pins_s[2];

    ssp_sticky #(.W(ssp_pkg::IRQ_W)) u_sticky (
        .clk(clk),
        .rst(rst),
        .set(irq_set),
        .clr(irq_clr),
        .mask(s.irq_mask),
        .stat(irq_stat),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.ready = 1'b1;
        n.resp = 1'b0;
        n.ev_rx_last = 1'b0;
        n.ev_tx_last = 1'b0;
        n.sclk_d = sclk_s;
        te = {s.ctrl[ssp_pkg::B_TE2], s.ctrl[ssp_pkg::B_TE1], s.ctrl[ssp_pkg::B_TE0]};
        te_new = {hwdata[ssp_pkg::B_TE2], hwdata[ssp_pkg::B_TE1], hwdata[ssp_pkg::B_TE0]};
        // With no transmitter enabled, transmitter 0 stands for the set
        tx_en = (te == 3'h0) ? 3'h1 : te;
        net = s.ctrl[ssp_pkg::B_NET];
        last_ok = net & (s.dc != ssp_pkg::DC_ON_DEMAND);
        take = hsel & hready & htrans[1];
        wr_dp = s.ap_valid & s.ap_wr;
        sclk_rise = sclk_s & ~s.sclk_d;
        new_word = 1'b0;
        word_end = 1'b0;
        irq_clr = 6'h00;

        // Address phase: latch write, answer reads next cycle
        n.ap_valid = take;
        n.ap_wr = hwrite;
        n.ap_addr = haddr[5:0];
        n.rdata = 32'h00000000;
        if (take & ~hwrite) begin
            case (haddr[5:0])
                ssp_pkg::OFF_CTRL_B: n.rdata = {8'h00, s.ctrl};
                ssp_pkg::OFF_FRAME: n.rdata = {27'h0000000, s.dc};
                ssp_pkg::OFF_STATUS: begin
                    n.rdata[ssp_pkg::S_RDF] = s.rx_full_flag;
                    n.rdata[ssp_pkg::S_ROE] = s.rx_overrun_flag;
                    n.rdata[ssp_pkg::S_TDE] = s.tx_empty_flag;
                    n.rdata[ssp_pkg::S_TUE] = s.tx_underrun_flag;
                    // Arms both clear sequences
                    n.rx_arm = 1'b1;
                    n.tx_arm = 1'b1;
                end
                ssp_pkg::OFF_RX_DATA: begin
                    n.rdata = {24'h000000, s.rx_data};
                    n.rx_full_flag = 1'b0;
                    if (s.rx_arm) begin
                        n.rx_overrun_flag = 1'b0;
                        n.rx_arm = 1'b0;
                    end
                end
                ssp_pkg::OFF_TX0: n.rdata = {24'h000000, s.tx_buf[0]};
                ssp_pkg::OFF_TX1: n.rdata = {24'h000000, s.tx_buf[1]};
                ssp_pkg::OFF_TX2: n.rdata = {24'h000000, s.tx_buf[2]};
                ssp_pkg::OFF_IRQ_STAT: n.rdata = {26'h0000000, irq_stat};
                ssp_pkg::OFF_IRQ_MASK: n.rdata = {26'h0000000, s.irq_mask};
                default: n.rdata = 32'h00000000;
            endcase
        end

        // Data phase of a write
        if (wr_dp) begin
            case (s.ap_addr)
                ssp_pkg::OFF_CTRL_B: begin
                    n.ctrl = hwdata[23:0];
                    if (net) begin
                        n.tx_hold = s.tx_hold | (te & ~te_new);
                    end
                end
                ssp_pkg::OFF_FRAME: n.dc = hwdata[4:0];
                ssp_pkg::OFF_TX0: begin
                    n.tx_buf[0] = hwdata[7:0];
                    n.tx_wr[0] = 1'b1;
                end
                ssp_pkg::OFF_TX1: begin
                    n.tx_buf[1] = hwdata[7:0];
                    n.tx_wr[1] = 1'b1;
                end
                ssp_pkg::OFF_TX2: begin
                    n.tx_buf[2] = hwdata[7:0];
                    n.tx_wr[2] = 1'b1;
                end
                ssp_pkg::OFF_SLOT: begin
                    n.tx_empty_flag = 1'b0;
                    n.tx_wr = 3'h0;
                end
                ssp_pkg::OFF_IRQ_STAT: irq_clr = hwdata[5:0];
                ssp_pkg::OFF_IRQ_MASK: n.irq_mask = hwdata[5:0];
                ssp_pkg::OFF_SW_RESET: n.ctrl = ssp_pkg::CTRL_RESET;
                default: n.ctrl = n.ctrl;
            endcase
            if ((n.tx_wr & tx_en) == tx_en) begin
                n.tx_empty_flag = 1'b0;
                n.tx_wr = 3'h0;
                if (s.tx_arm) begin
                    n.tx_underrun_flag = 1'b0;
                    n.tx_arm = 1'b0;
                end
            end
        end

        // Link side runs after the bus so hardware sets win over clears
        if (sclk_rise) begin
            if (fs_s) begin
                new_word = 1'b1;
                n.slot = 5'h00;
                n.tx_act = te;
                n.tx_hold = 3'h0;
                n.link = ssp_pkg::LS_WORD;
            end else if (s.link == ssp_pkg::LS_WORD && s.bit_cnt == 4'h0) begin
                new_word = 1'b1;
                n.slot = s.slot + 5'h01;
            end
            if (n.link == ssp_pkg::LS_WORD) begin
                n.rx_sh = {s.rx_sh[6:0], rxd_s};
                n.bit_cnt = (new_word ? 4'h0 : s.bit_cnt) + 4'h1;
                for (int i = 0; i < 3; i++) begin
                    if (new_word) begin
                        n.tx_out[i] = s.tx_buf[i][7];
                        n.tx_sh[i] = {s.tx_buf[i][6:0], 1'b0};
                    end else begin
                        n.tx_out[i] = s.tx_sh[i][7];
                        n.tx_sh[i] = {s.tx_sh[i][6:0], 1'b0};
                    end
                end
            end
            if (new_word) begin
                // Nothing written since last load: old word goes out again
                if (s.tx_empty_flag && (n.tx_act != 3'h0)) begin
                    n.tx_underrun_flag = 1'b1;
                end
                n.tx_empty_flag = 1'b1;
                n.tx_wr = 3'h0;
                if (last_ok && n.slot == s.dc) begin
                    n.ev_tx_last = s.ctrl[ssp_pkg::B_TX_FINAL_SLOT_IRQ_EN];
                end
            end
            if (n.link == ssp_pkg::LS_WORD && n.bit_cnt == ssp_pkg::WORD_BITS) begin
                word_end = 1'b1;
                n.bit_cnt = 4'h0;
                if (s.ctrl[ssp_pkg::B_RE]) begin
                    n.rx_data = n.rx_sh;
                    if (s.rx_full_flag) begin
                        n.rx_overrun_flag = 1'b1;
                    end
                    n.rx_full_flag = 1'b1;
                end
                if (last_ok && n.slot == s.dc) begin
                    n.ev_rx_last = s.ctrl[ssp_pkg::B_RX_FINAL_SLOT_IRQ_EN];
                end
                n.tx_act = n.tx_act & ~n.tx_hold;
                if (!net || n.slot == s.dc) begin
                    n.link = ssp_pkg::LS_WAIT;
                end
            end
        end
        n.tx_oe_n = ~n.tx_act;

        n.req_rx_exc = n.ctrl[ssp_pkg::B_RX_EXCEPTION_IRQ_EN] & n.rx_full_flag & n.rx_overrun_flag;
        n.req_rx = n.ctrl[ssp_pkg::B_RIE] & n.rx_full_flag & ~n.req_rx_exc;
        n.req_tx_exc = n.ctrl[ssp_pkg::B_TX_EXCEPTION_IRQ_EN] & n.tx_empty_flag & n.tx_underrun_flag;
        n.req_tx = n.ctrl[ssp_pkg::B_TIE] & n.tx_empty_flag & ~n.req_tx_exc;

        irq_set = 6'h00;
        irq_set[ssp_pkg::I_RX_EXC] = n.req_rx_exc;
        irq_set[ssp_pkg::I_TX_EXC] = n.req_tx_exc;
        irq_set[ssp_pkg::I_RX_LAST] = n.ev_rx_last;
        irq_set[ssp_pkg::I_TX_LAST] = n.ev_tx_last;
        irq_set[ssp_pkg::I_RX] = n.req_rx;
        irq_set[ssp_pkg::I_TX] = n.req_tx;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= ssp_pkg::CTRL_RESET;
            s.dc <= ssp_pkg::DC_RESET;
            s.tx_empty_flag <= 1'b1;
            s.tx_oe_n <= 3'h7;
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = s.ready;
    assign hresp = s.resp;
    assign hrdata = s.rdata;
    assign tx_data_out = s.tx_out;
    assign tx_oe_n = s.tx_oe_n;
    assign req_rx = s.req_rx;
    assign req_rx_exc = s.req_rx_exc;
    assign req_tx = s.req_tx;
    assign req_tx_exc = s.req_tx_exc;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic ctrl_wr;
    assign ctrl_wr = wr_dp && (s.ap_addr == ssp_pkg::OFF_CTRL_B || s.ap_addr == ssp_pkg::OFF_SW_RESET);

    property p_rx_exc;
        (s.ctrl[ssp_pkg::B_RX_EXCEPTION_IRQ_EN] && s.rx_full_flag && s.rx_overrun_flag && !take && !ctrl_wr) |=> req_rx_exc;
    endproperty
    a_rx_exc: assert property (p_rx_exc) else $error("rx exception not raised");

    property p_rx_prio;
        req_rx_exc |-> !req_rx;
    endproperty
    a_rx_prio: assert property (p_rx_prio) else $error("rx data beside exception");

    property p_tx_exc;
        (s.ctrl[ssp_pkg::B_TX_EXCEPTION_IRQ_EN] && s.tx_empty_flag && s.tx_underrun_flag && !wr_dp) |=> req_tx_exc;
    endproperty
    a_tx_exc: assert property (p_tx_exc) else $error("tx exception not raised");

    property p_tx_prio;
        req_tx_exc |-> !req_tx;
    endproperty
    a_tx_prio: assert property (p_tx_prio) else $error("tx data beside exception");

    sequence s_rx_read;
        take && !hwrite && haddr[5:0] == ssp_pkg::OFF_RX_DATA && !word_end;
    endsequence
    property p_rx_clr;
        s_rx_read |=> !s.rx_full_flag && !req_rx;
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx read left full flag");

    property p_last_inhib;
        (s.dc == ssp_pkg::DC_ON_DEMAND) |=> !s.ev_rx_last && !s.ev_tx_last;
    endproperty
    a_last_inhib: assert property (p_last_inhib) else $error("last slot in on-demand");

    property p_slot_clr;
        (wr_dp && s.ap_addr == ssp_pkg::OFF_SLOT && !new_word) |=> !s.tx_empty_flag;
    endproperty
    a_slot_clr: assert property (p_slot_clr) else $error("slot write left empty flag");

    property p_sw_reset;
        (wr_dp && s.ap_addr == ssp_pkg::OFF_SW_RESET) |=> s.ctrl == ssp_pkg::CTRL_RESET ##1 !req_rx;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("soft reset left control");

    property p_rx_drop;
        (!s.ctrl[ssp_pkg::B_RIE] && !ctrl_wr) |=> !req_rx;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx request without enable");

    property p_tx_hold;
        (s.tx_hold[0] && word_end && !fs_s) |=> tx_oe_n[0];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("held transmitter still driving");
endmodule : ssp_top
`default_nettype wire

// file: ssp_pkg.sv
// Purpose: shared constants of the serial port interrupt block
// Assumes: AHB-Lite word registers, 8-bit serial words
// Notes: offsets are byte addresses within the slave window
package ssp_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_CTRL_B = 6'h00;
    localparam logic [5:0] OFF_FRAME = 6'h04;
    localparam logic [5:0] OFF_STATUS = 6'h08;
    localparam logic [5:0] OFF_RX_DATA = 6'h0c;
    localparam logic [5:0] OFF_TX0 = 6'h10;
    localparam logic [5:0] OFF_TX1 = 6'h14;
    localparam logic [5:0] OFF_TX2 = 6'h18;
    localparam logic [5:0] OFF_SLOT = 6'h1c;
    localparam logic [5:0] OFF_IRQ_STAT = 6'h20;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h24;
    localparam logic [5:0] OFF_SW_RESET = 6'h28;
    // ------------------------------------------------------------
    // serial_control_b fields and reset values
    // ------------------------------------------------------------
    localparam logic [23:0] CTRL_RESET = 24'h000000;
    localparam int B_RX_EXCEPTION_IRQ_EN = 23;
    localparam int B_TX_EXCEPTION_IRQ_EN = 22;
    localparam int B_RX_FINAL_SLOT_IRQ_EN = 21;
    localparam int B_TX_FINAL_SLOT_IRQ_EN = 20;
    localparam int B_RIE = 19;
    localparam int B_TIE = 18;
    localparam int B_RE = 17;
    localparam int B_TE0 = 16;
    localparam int B_TE1 = 15;
    localparam int B_TE2 = 14;
    localparam int B_NET = 13;
    localparam logic [4:0] DC_RESET = 5'h00;
    localparam logic [4:0] DC_ON_DEMAND = 5'h00;
    // ------------------------------------------------------------
    // Status bits, interrupt bits, link sizes
    // ------------------------------------------------------------
    localparam int S_RDF = 0;
    localparam int S_ROE = 1;
    localparam int S_TDE = 2;
    localparam int S_TUE = 3;
    localparam int I_RX_EXC = 0;
    localparam int I_TX_EXC = 1;
    localparam int I_RX_LAST = 2;
    localparam int I_TX_LAST = 3;
    localparam int I_RX = 4;
    localparam int I_TX = 5;
    localparam int IRQ_W = 6;
    localparam logic [3:0] WORD_BITS = 4'h8;
    typedef enum logic [0:0] {LS_WAIT = 1'b0, LS_WORD = 1'b1} ssp_link_t;
endpackage : ssp_pkg

// file: ssp_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock
// Assumes: one clock, synchronous reset
// Notes: only the second stage is visible
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssp_sync_t;
    ssp_sync_t s;
    ssp_sync_t n;

    // Stage one feeds stage two only
    always_comb begin
        n.s1 = d;
        n.s2 = s.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign q = s.s2;
endmodule : ssp_sync
`default_nettype wire

// file: ssp_sticky.sv
// Purpose: sticky interrupt status with mask and one level output
// Assumes: clear by writing ones, set wins over clear
// Notes: output registered
`timescale 1ns/1ps
`default_nettype none
module ssp_sticky #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] mask,
    output logic [W-1:0] stat,
    output logic irq
);
    typedef struct packed {
        logic [W-1:0] stat;
        logic irq;
    } ssp_stk_t;
    ssp_stk_t s;
    ssp_stk_t n;

    // Clear first, then set, so an event on the clear cycle survives
    always_comb begin
        n.stat = (s.stat & ~clr) | set;
        n.irq = |(n.stat & mask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign stat = s.stat;
    assign irq = s.irq;
endmodule : ssp_sticky
`default_nettype wire

// file: ssp_peer.sv
// Purpose: link peer that sends words on the bit clock
// Assumes: bit clock period 800 ns, data changed on the falling edge
// Notes: clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    output logic sclk_pin,
    output logic fs_pin,
    output logic rxd_pin
);
    // ------------
    // Frame source
    // ------------
    initial begin
        sclk_pin = 1'b0;
        fs_pin = 1'b0;
        rxd_pin = 1'b0;
    end
    // Words go back to back, MSB first; sync marks the first bit only
    task automatic send_frame(input int n, input logic [7:0] w);
        #30;
        for (int k = 0; k < n; k++) begin
            for (int b = 7; b >= 0; b--) begin
                fs_pin = (k == 0) && (b == 7);
                rxd_pin = w[b];
                #400 sclk_pin = 1'b1;
                #400 sclk_pin = 1'b0;
            end
        end
        // Idle line shows the inverse so stale data cannot pass as valid
        fs_pin = 1'b0;
        rxd_pin = ~w[0];
    endtask : send_frame
endmodule : ssp_peer
`default_nettype wire

// file: ssp_top_tb_top.sv
// Purpose: self-checking bench for the serial port interrupt block
// Assumes: zero wait AHB slave, requests registered one cycle late
// Notes: link latency is covered by a fixed settle after each frame
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ssp_top_tb_top;
    typedef struct packed {logic [31:0] ctrl; logic [3:0] req;} ssp_row_t;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp, irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, tx_oe_n, tx_data_out;
    logic sclk_pin, fs_pin, rxd_pin, req_rx, req_rx_exc, req_tx, req_tx_exc;
    int n_fail = 0, total_checks = 0;
    ssp_row_t rows [4] = '{'{32'h0, 4'h0}, '{32'h40000, 4'h1}, '{32'h400000, 4'h0}, '{32'h80000, 4'h0}};
    always #50 clk = ~clk;
    ssp_top dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sclk_pin(sclk_pin), .fs_pin(fs_pin), .rxd_pin(rxd_pin), .tx_data_out(tx_data_out),
        .tx_oe_n(tx_oe_n), .req_rx(req_rx), .req_rx_exc(req_rx_exc), .req_tx(req_tx),
        .req_tx_exc(req_tx_exc), .irq(irq));
    ssp_peer peer (.sclk_pin(sclk_pin), .fs_pin(fs_pin), .rxd_pin(rxd_pin));
    // ------------
    // Bus and checks
    // ------------
    // One single word transfer; address held until ready, data until ready
    task automatic ahb(input logic wr, input logic [5:0] off, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= {26'h0, off};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb
    task automatic wr(input logic [5:0] off, input logic [31:0] v);
        ahb(1'b1, off, v, d);
        repeat (2) @(posedge clk);
    endtask : wr
    task automatic rd_chk(input logic [5:0] off, input logic [31:0] e);
        ahb(1'b0, off, 32'h0, d);
        `CHK(d, e)
    endtask : rd_chk
    // Frame then settle past synchroniser and registered requests
    task automatic frame(input int n, input logic [7:0] w);
        peer.send_frame(n, w);
        repeat (8) @(posedge clk);
    endtask : frame
    function automatic logic [3:0] reqs();
        return {req_rx_exc, req_rx, req_tx_exc, req_tx};
    endfunction : reqs
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog well above the expected 70 us run
    initial begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end
    // ------------
    // Main sequence
    // ------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(ssp_pkg::OFF_CTRL_B, 32'h0);
        rd_chk(ssp_pkg::OFF_STATUS, 32'h4);
        `CHK({hresp, tx_data_out, irq, tx_oe_n, reqs()}, 12'h070)
        // Enable rows against idle flags: only transmit empty is up
        for (int i = 0; i < 4; i++) begin
            wr(ssp_pkg::OFF_CTRL_B, rows[i].ctrl);
            `CHK(reqs(), rows[i].req)
            rd_chk(ssp_pkg::OFF_CTRL_B, rows[i].ctrl);
        end
        // Receive, then overrun with exception over normal receive
        wr(ssp_pkg::OFF_CTRL_B, 32'h8a0000);
        frame(1, 8'ha5);
        `CHK(reqs(), 4'h4)
        rd_chk(ssp_pkg::OFF_RX_DATA, 32'ha5);
        repeat (2) @(posedge clk);
        `CHK(reqs(), 4'h0)
        frame(1, 8'h3c);
        frame(1, 8'h5a);
        `CHK(reqs(), 4'h8)
        wr(ssp_pkg::OFF_CTRL_B, 32'h0a0000);
        `CHK(reqs(), 4'h4)
        wr(ssp_pkg::OFF_CTRL_B, 32'h8a0000);
        rd_chk(ssp_pkg::OFF_STATUS, 32'h7);
        rd_chk(ssp_pkg::OFF_RX_DATA, 32'h5a);
        rd_chk(ssp_pkg::OFF_STATUS, 32'h4);
        // Underrun on an unfed transmitter, cleared by status then data
        wr(ssp_pkg::OFF_CTRL_B, 32'h450000);
        frame(1, 8'h00);
        `CHK(reqs(), 4'h2)
        rd_chk(ssp_pkg::OFF_STATUS, 32'hc);
        wr(ssp_pkg::OFF_TX0, 32'h11);
        `CHK(reqs(), 4'h0)
        frame(1, 8'h00);
        `CHK(reqs(), 4'h1)
        `CHK({tx_data_out[0], tx_oe_n[0]}, 2'h2)
        wr(ssp_pkg::OFF_SLOT, 32'h0);
        `CHK(reqs(), 4'h0)
        // Final slot events, mask and write-one clear
        wr(ssp_pkg::OFF_CTRL_B, 32'h302000);
        wr(ssp_pkg::OFF_FRAME, 32'h1);
        wr(ssp_pkg::OFF_IRQ_STAT, 32'h3f);
        wr(ssp_pkg::OFF_IRQ_MASK, 32'hc);
        frame(2, 8'h0f);
        ahb(1'b0, ssp_pkg::OFF_IRQ_STAT, 32'h0, d);
        `CHK(d[3:2], 2'h3)
        `CHK(irq, 1'b1)
        wr(ssp_pkg::OFF_IRQ_MASK, 32'h0);
        `CHK(irq, 1'b0)
        wr(ssp_pkg::OFF_IRQ_MASK, 32'hc);
        wr(ssp_pkg::OFF_IRQ_STAT, 32'hc);
        `CHK(irq, 1'b0)
        wr(ssp_pkg::OFF_FRAME, 32'h0);
        frame(1, 8'h0f);
        ahb(1'b0, ssp_pkg::OFF_IRQ_STAT, 32'h0, d);
        `CHK({irq, d[3:2]}, 3'h0)
        // Software reset clears every control bit
        wr(ssp_pkg::OFF_CTRL_B, 32'hfc0000);
        wr(ssp_pkg::OFF_SW_RESET, 32'h1);
        rd_chk(ssp_pkg::OFF_CTRL_B, 32'h0);
        tally_and_finish();
    end
endmodule : ssp_top_tb_top
`default_nettype wire
